// ---- verilog/cec_pkg.sv ----
// cec_pkg: register map, field positions, timing counts and carrier types of the cec receive block
// assumes a 25 MHz module clock and a 32-bit register port with byte offsets
package cec_pkg;

  localparam int DW = 32;
  localparam int AW = 8;

  // register offsets
  localparam logic [AW-1:0] OFS_EN   = 8'h00;
  localparam logic [AW-1:0] OFS_ADDR = 8'h04;
  localparam logic [AW-1:0] OFS_RST  = 8'h08;
  localparam logic [AW-1:0] OFS_REN  = 8'h0c;
  localparam logic [AW-1:0] OFS_RBUF = 8'h10;
  localparam logic [AW-1:0] OFS_RCR1 = 8'h14;
  localparam logic [AW-1:0] OFS_RCR2 = 8'h18;
  localparam logic [AW-1:0] OFS_RCR3 = 8'h1c;
  localparam logic [AW-1:0] OFS_IST  = 8'h40;
  localparam logic [AW-1:0] OFS_IMSK = 8'h44;

  // field positions
  localparam int BIT_EN     = 0;
  localparam int BIT_IDLE   = 1;
  localparam int BIT_RST    = 0;
  localparam int BIT_REN    = 0;
  localparam int BIT_OTH    = 0;
  localparam int BIT_ACKDIS = 24;
  localparam int ADDR_W     = 16;
  localparam int IRQ_W      = 3;
  localparam int IRQ_RX     = 0;
  localparam int IRQ_EOM    = 1;
  localparam int IRQ_ERR    = 2;
  localparam logic [3:0] BCAST_DST = 4'hf;

  // reset values
  localparam logic [DW-1:0]     RCR_RST  = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

  // timing: module clock, sample tick and bit shapes
  localparam int CLK_NS       = 40;
  localparam int TICK_NS      = 50000;
  localparam int TICK_CYC     = TICK_NS / CLK_NS;
  localparam int SAMPLE_NS    = 1050000;
  localparam int BIT_MAX_NS   = 2050000;
  localparam int ZERO_LOW_NS  = 1500000;
  localparam int START_MIN_NS = 3500000;
  localparam int START_MAX_NS = 3900000;
  localparam logic [7:0] SAMPLE_T    = 8'(SAMPLE_NS / TICK_NS);
  localparam logic [7:0] BIT_MAX_T   = 8'(BIT_MAX_NS / TICK_NS);
  localparam logic [7:0] ZERO_LOW_T  = 8'(ZERO_LOW_NS / TICK_NS);
  localparam logic [7:0] START_MIN_T = 8'((START_MIN_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [7:0] START_MAX_T = 8'(START_MAX_NS / TICK_NS);
  localparam logic [3:0] LAST_BIT    = 4'h9;
  localparam logic [3:0] LAST_DATA   = 4'h7;

  typedef struct packed {
    logic            wr;
    logic            rd;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   wdata;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic value;
    logic start;
    logic err;
  } bit_evt_t;

  typedef struct packed {
    logic       ack;
    logic       eom;
    logic [7:0] data;
  } rx_word_t;

  typedef enum logic [0:0] {RX_IDLE, RX_BITS} rx_state_t;

endpackage : cec_pkg

// ---- verilog/cec_sync.sv ----
// cec_sync: two-flop synchroniser for the bus line input
// assumes the input is asynchronous to mclk
`timescale 1ns/1ps
module cec_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // reset to the released level so no false falling edge follows reset
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule : cec_sync

// ---- verilog/cec_bit_decoder.sv ----
// cec_bit_decoder: classifies each low pulse of the line as start bit, data bit or error
// assumes lineLow is synchronised and tick is a one-cycle pulse every sample period
`timescale 1ns/1ps
module cec_bit_decoder
  import cec_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        clear,
  input  wire logic        tick,
  input  wire logic        lineLow,
  output cec_pkg::bit_evt_t evt
);
  logic     lowPrev_reg;
  logic [7:0] lowCnt_reg;
  bit_evt_t evt_reg;
  logic     rise;

  assign rise = lowPrev_reg && !lineLow;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lowPrev_reg <= 1'b0;
      lowCnt_reg  <= 8'h00;
    end else if (clear) begin
      lowPrev_reg <= 1'b0;
      lowCnt_reg  <= 8'h00;
    end else if (clkEn) begin
      lowPrev_reg <= lineLow;
      if (lineLow && !lowPrev_reg) begin
        lowCnt_reg <= 8'h00;
      end else if (tick && lineLow && lowCnt_reg != 8'hff) begin
        lowCnt_reg <= lowCnt_reg + 8'h01;
      end
    end
  end

  // a short low is a one, a long low a zero, a very long low a start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_reg <= '0;
    end else if (clear) begin
      evt_reg <= '0;
    end else if (clkEn) begin
      evt_reg <= '0;
      if (rise) begin
        if (lowCnt_reg < SAMPLE_T) begin
          evt_reg.valid <= 1'b1;
          evt_reg.value <= 1'b1;
        end else if (lowCnt_reg <= BIT_MAX_T) begin
          evt_reg.valid <= 1'b1;
        end else if (lowCnt_reg >= START_MIN_T && lowCnt_reg <= START_MAX_T) begin
          evt_reg.start <= 1'b1;
        end else begin
          evt_reg.err <= 1'b1;
        end
      end
    end
  end

  assign evt = evt_reg;
endmodule : cec_bit_decoder

// ---- verilog/cec_ctrl.sv ----
// cec_ctrl: register port, soft reset, receive enable and receive buffer of the cec controller
// assumes a single-cycle strobe register port and an open-drain bus line resolved outside
//
// Summary of operation
// - writing one to the soft reset bit halts the controller and resets registers
// - soft reset aborts reception at once and drops partial data
// - soft reset ends an acknowledge drive at once and releases the line
// - soft reset clears every register except the module enable register
// - receive enable one arms the receiver, zero disables reception
// - receive enable reads back the receiver's actual running state
// - enable changes take some cycles; read-back follows only once applied
// - receive buffer holds last byte in bits 7-0, bit 7 msb
// - receive buffer bit 8 holds the received end-of-message bit
// - receive buffer bit 9 holds the acknowledge bit sampled on the line
// - writes to the receive buffer change nothing
// - module enable low freezes everything but that register, keeping settings
`timescale 1ns/1ps
module cec_ctrl
  import cec_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire cec_pkg::bus_req_t busReq,
  output logic [cec_pkg::DW-1:0] rdData,
  input  wire logic              cecIn,
  output logic                   cecOut,
  output logic                   cecOe,
  output logic                   irq
);
  import cec_pkg::*;

  generate
    if (TICK_DIV < 2 || TICK_DIV > 2047) begin : g_bad_div
      $error("TICK_DIV out of range");
    end
  endgenerate

  logic                modEn_reg;
  logic                idleEn_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic                renReq_reg;
  logic                rxActive_reg;
  logic [DW-1:0]       rcr1_reg;
  logic [DW-1:0]       rcr2_reg;
  logic [DW-1:0]       rcr3_reg;
  rx_word_t            rxBuf_reg;
  logic [IRQ_W-1:0]    irqStat_reg;
  logic [IRQ_W-1:0]    irqMask_reg;
  logic [10:0]         div_reg;
  rx_state_t           rxState_reg;
  logic [3:0]          bitIdx_reg;
  logic [9:0]          shift_reg;
  logic                header_reg;
  logic                dstHit_reg;
  logic                mine_reg;
  logic [7:0]          ackCnt_reg;
  logic                linePrev_reg;
  logic                oe_reg;
  logic [DW-1:0]       rdData_reg;

  logic                wrEn;
  logic                softRst;
  logic                tick;
  logic                lineLow;
  logic                lineSync;
  logic                decClear;
  bit_evt_t            evt;
  logic                blkDone;
  logic                blkStore;
  rx_word_t            blkWord;
  logic [7:0]          curByte;
  logic                wantAck;
  logic [IRQ_W-1:0]    irqSet;
  logic [DW-1:0]       rdMux;

  // register writes only reach the block while its clock is enabled
  assign wrEn    = busReq.wr && modEn_reg;
  // soft reset is a register write, so it is refused while the module is disabled
  assign softRst = wrEn && busReq.addr == OFS_RST && busReq.wdata[BIT_RST];

  cec_sync u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (cecIn),
    .q     (lineSync)
  );
  assign lineLow = !lineSync;

  // module enable register: the only state soft reset leaves alone
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modEn_reg  <= 1'b0;
      idleEn_reg <= 1'b0;
    end else if (busReq.wr && busReq.addr == OFS_EN) begin
      modEn_reg  <= busReq.wdata[BIT_EN];
      idleEn_reg <= busReq.wdata[BIT_IDLE];
    end
  end

  // sample tick divider
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 11'h000;
    end else if (softRst) begin
      div_reg <= 11'h000;
    end else if (modEn_reg) begin
      div_reg <= (div_reg == 11'(TICK_DIV - 1)) ? 11'h000 : div_reg + 11'h001;
    end
  end
  assign tick = modEn_reg && div_reg == 11'(TICK_DIV - 1);

  // configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg    <= ADDR_RST;
      rcr1_reg    <= RCR_RST;
      rcr2_reg    <= RCR_RST;
      rcr3_reg    <= RCR_RST;
      irqMask_reg <= '0;
      renReq_reg  <= 1'b0;
    end else if (softRst) begin
      addr_reg    <= ADDR_RST;
      rcr1_reg    <= RCR_RST;
      rcr2_reg    <= RCR_RST;
      rcr3_reg    <= RCR_RST;
      irqMask_reg <= '0;
      renReq_reg  <= 1'b0;
    end else if (wrEn) begin
      case (busReq.addr)
        OFS_ADDR: addr_reg    <= busReq.wdata[ADDR_W-1:0];
        OFS_RCR1: rcr1_reg    <= busReq.wdata;
        OFS_RCR2: rcr2_reg    <= busReq.wdata;
        OFS_RCR3: rcr3_reg    <= busReq.wdata;
        OFS_IMSK: irqMask_reg <= busReq.wdata[IRQ_W-1:0];
        OFS_REN:  renReq_reg  <= busReq.wdata[BIT_REN];
        default:  ;
      endcase
    end
  end

  // the receiver takes the request only on a sample tick
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxActive_reg <= 1'b0;
    end else if (softRst) begin
      rxActive_reg <= 1'b0;
    end else if (tick) begin
      rxActive_reg <= renReq_reg;
    end
  end

  assign decClear = softRst || !rxActive_reg;

  cec_bit_decoder u_dec (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .clkEn   (modEn_reg),
    .clear   (decClear),
    .tick    (tick),
    .lineLow (lineLow),
    .evt     (evt)
  );

  assign curByte  = {shift_reg[6:0], evt.value};
  assign blkDone  = rxState_reg == RX_BITS && evt.valid && bitIdx_reg == LAST_BIT;
  assign blkStore = blkDone && (mine_reg || rcr1_reg[BIT_OTH]);
  assign blkWord  = '{ack: evt.value, eom: shift_reg[0], data: shift_reg[8:1]};
  assign wantAck  = dstHit_reg && (header_reg || !rcr1_reg[BIT_ACKDIS]);

  // block assembly: eight data bits, end-of-message, acknowledge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_reg <= RX_IDLE;
      bitIdx_reg  <= 4'h0;
      shift_reg   <= 10'h000;
      header_reg  <= 1'b0;
      dstHit_reg  <= 1'b0;
      mine_reg    <= 1'b0;
    end else if (decClear) begin
      rxState_reg <= RX_IDLE;
      bitIdx_reg  <= 4'h0;
      shift_reg   <= 10'h000;
      header_reg  <= 1'b0;
      dstHit_reg  <= 1'b0;
      mine_reg    <= 1'b0;
    end else if (modEn_reg) begin
      if (evt.start) begin
        rxState_reg <= RX_BITS;
        bitIdx_reg  <= 4'h0;
        header_reg  <= 1'b1;
      end else if (evt.err) begin
        rxState_reg <= RX_IDLE;
        bitIdx_reg  <= 4'h0;
      end else if (evt.valid) begin
        case (rxState_reg)
          RX_BITS: begin
            shift_reg <= {shift_reg[8:0], evt.value};
            if (bitIdx_reg == LAST_DATA && header_reg) begin
              dstHit_reg <= addr_reg[curByte[3:0]];
              mine_reg   <= addr_reg[curByte[3:0]] || curByte[3:0] == BCAST_DST;
            end
            if (bitIdx_reg == LAST_BIT) begin
              bitIdx_reg <= 4'h0;
              header_reg <= 1'b0;
              if (shift_reg[0]) begin
                rxState_reg <= RX_IDLE;
              end
            end else begin
              bitIdx_reg <= bitIdx_reg + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // receive buffer has no bus write path
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_reg <= '0;
    end else if (softRst) begin
      rxBuf_reg <= '0;
    end else if (modEn_reg && blkStore) begin
      rxBuf_reg <= blkWord;
    end
  end

  // acknowledge: stretch the initiator's low into a zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linePrev_reg <= 1'b0;
      ackCnt_reg   <= 8'h00;
      oe_reg       <= 1'b0;
    end else if (decClear) begin
      linePrev_reg <= 1'b0;
      ackCnt_reg   <= 8'h00;
      oe_reg       <= 1'b0;
    end else if (modEn_reg) begin
      linePrev_reg <= lineLow;
      if (rxState_reg == RX_BITS && bitIdx_reg == LAST_BIT && lineLow && !linePrev_reg && wantAck) begin
        ackCnt_reg <= ZERO_LOW_T;
        oe_reg     <= 1'b1;
      end else if (tick && ackCnt_reg != 8'h00) begin
        ackCnt_reg <= ackCnt_reg - 8'h01;
        oe_reg     <= ackCnt_reg != 8'h01;
      end
    end
  end
  assign cecOe  = oe_reg;
  assign cecOut = 1'b0;

  // sticky events; a new event wins over a clear in the same cycle
  assign irqSet = {evt.err && rxState_reg == RX_BITS, blkStore && blkWord.eom, blkStore};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_reg <= '0;
    end else if (softRst) begin
      irqStat_reg <= '0;
    end else if (modEn_reg) begin
      if (wrEn && busReq.addr == OFS_IST) begin
        irqStat_reg <= (irqStat_reg & ~busReq.wdata[IRQ_W-1:0]) | irqSet;
      end else begin
        irqStat_reg <= irqStat_reg | irqSet;
      end
    end
  end
  assign irq = |(irqStat_reg & irqMask_reg);

  always_comb begin
    rdMux = '0;
    case (busReq.addr)
      OFS_EN:   rdMux = DW'({idleEn_reg, modEn_reg});
      OFS_ADDR: rdMux = DW'(addr_reg);
      OFS_RST:  rdMux = '0;
      OFS_REN:  rdMux = DW'(rxActive_reg);
      OFS_RBUF: rdMux = DW'(rxBuf_reg);
      OFS_RCR1: rdMux = rcr1_reg;
      OFS_RCR2: rdMux = rcr2_reg;
      OFS_RCR3: rdMux = rcr3_reg;
      OFS_IST:  rdMux = DW'(irqStat_reg);
      OFS_IMSK: rdMux = DW'(irqMask_reg);
      default:  rdMux = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= busReq.rd ? rdMux : '0;
    end
  end
  assign rdData = rdData_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  rst_halt_a: assert property (softRst |=> irqStat_reg == '0 && !irq)
    else $error("soft reset left events pending");
  rst_drop_a: assert property (softRst |=> rxState_reg == RX_IDLE && bitIdx_reg == 4'h0 && rxBuf_reg == '0)
    else $error("soft reset kept reception state");
  rst_line_a: assert property (softRst |=> !cecOe [*2])
    else $error("line still driven after soft reset");
  rst_keep_a: assert property (softRst |=> modEn_reg && $stable(idleEn_reg) && addr_reg == ADDR_RST)
    else $error("soft reset handled enable or address wrongly");
  ren_arm_a: assert property (tick && !softRst |=> rxActive_reg == $past(renReq_reg))
    else $error("receiver did not follow enable request");
  ren_read_a: assert property (busReq.rd && busReq.addr == OFS_REN |=> rdData == DW'($past(rxActive_reg)))
    else $error("enable read-back is not receiver state");
  ren_lag_a: assert property (!tick && !softRst |=> $stable(rxActive_reg))
    else $error("receiver state changed off tick");
  buf_fill_a: assert property (blkStore && modEn_reg && !softRst |=> rxBuf_reg == $past(blkWord))
    else $error("buffer not loaded from block");
  buf_ro_a: assert property (busReq.wr && busReq.addr == OFS_RBUF && !blkStore |=> $stable(rxBuf_reg))
    else $error("buffer changed by a bus write");
  gate_hold_a: assert property (!modEn_reg |=> $stable(addr_reg) && $stable(rcr1_reg) && $stable(rxBuf_reg))
    else $error("state moved while module disabled");
  rst_self_a: assert property (busReq.rd && busReq.addr == OFS_RST |=> rdData == '0)
    else $error("soft reset bit read as one");
  ren_stop_a: assert property (!rxActive_reg |=> rxState_reg == RX_IDLE && !cecOe)
    else $error("stopped receiver still assembling or driving");
  ack_slot_a: assert property ($rose(cecOe) |-> rxState_reg == RX_BITS && bitIdx_reg == LAST_BIT)
    else $error("line driven outside the acknowledge slot");

  rst_mid_c: cover property (rxState_reg == RX_BITS && softRst);
  blk_store_c: cover property (blkStore && blkWord.eom);
  ack_drive_c: cover property ($rose(cecOe));
  irq_up_c: cover property ($rose(irq));
  err_frame_c: cover property (irqSet[IRQ_ERR]);
endmodule : cec_ctrl

// ---- dv/cec_peer.sv ----
// cec_peer: behavioural initiator on the single-wire line, sends start bits and ten-bit blocks
// assumes a pull-up on the line and tasks called right after a rising edge of mclk
`timescale 1ns/1ps
module cec_peer #(
  parameter int TICK_DIV = 4
) (
  input  wire logic mclk,
  input  wire logic cecOe,
  output logic      lineLevel
);
  logic pullLow = 1'b0;

  // wired-and with the pull-up: anyone pulling wins
  assign lineLevel = !(pullLow || cecOe);

  task automatic holdTicks(input logic low, input int ticks);
    pullLow <= low;
    repeat (ticks * TICK_DIV) @(posedge mclk);
  endtask : holdTicks

  // low times sit well inside each class, slow ones near the far edge
  task automatic sendBit(input logic b, input logic slow);
    int lowT;
    lowT = b ? (slow ? 18 : 8) : (slow ? 38 : 26);
    holdTicks(1'b1, lowT);
    holdTicks(1'b0, 48 - lowT);
  endtask : sendBit

  task automatic sendStart();
    @(posedge mclk);
    holdTicks(1'b1, 75);
    holdTicks(1'b0, 15);
  endtask : sendStart

  // ack slot sent as a one (short low); a follower stretches its low into a zero
  task automatic sendBlock(input logic [7:0] data, input logic eom, input logic slow);
    for (int i = 7; i >= 0; i--) begin
      sendBit(data[i], slow);
    end
    sendBit(eom, slow);
    sendBit(1'b1, slow);
  endtask : sendBlock
endmodule : cec_peer

// ---- dv/cec_reset_and_receive_regs_test.sv ----
// cec_reset_and_receive_regs_test: random frames, ack, soft reset and register checks on cec_ctrl
// assumes cec_peer as the far side and a shortened sample tick of 4 clocks
`timescale 1ns/1ps
module cec_reset_and_receive_regs_test;
  import cec_pkg::*;
  localparam int TDIV = 4;
  logic              mclk;
  logic              rst_n;
  bus_req_t          busReq;
  logic [DW-1:0]     rdData;
  logic              cecIn;
  logic              cecOe;
  logic              cecOut;
  logic              irq;
  logic              maskOn;
  int                failCount;
  int                samplesChecked;
  localparam logic [7:0] zeroAddr [10] = '{OFS_RST, OFS_REN, OFS_RBUF, OFS_RCR1, OFS_RCR2,
                                           OFS_RCR3, OFS_ADDR, OFS_IST, OFS_IMSK, 8'h30};

  cec_ctrl #(.TICK_DIV(TDIV)) dut_u (.mclk(mclk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
    .cecIn(cecIn), .cecOut(cecOut), .cecOe(cecOe), .irq(irq));
  cec_peer #(.TICK_DIV(TDIV)) peer_u (.mclk(mclk), .cecOe(cecOe), .lineLevel(cecIn));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic testDone();
    $display("comparisons %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : testDone

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    busReq.wr    <= 1'b1;
    busReq.addr  <= a;
    busReq.wdata <= d;
    @(posedge mclk);
    busReq.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge mclk);
    busReq.rd   <= 1'b1;
    busReq.addr <= a;
    @(posedge mclk);
    busReq.rd   <= 1'b0;
    #1;
    d = rdData;
  endtask : rd

  task automatic rdChk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] d;
    rd(a, d);
    check(d, e);
  endtask : rdChk

  function automatic logic [31:0] expBuf(input logic [7:0] data, input logic eom, input logic ack);
    return {22'h0, ack, eom, data};
  endfunction : expBuf

  // bounded poll of the receiver's live state
  task automatic waitRen(input logic v);
    logic [DW-1:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(OFS_REN, d);
      if (d[0] === v) break;
    end
    check(d, {31'h0, v});
    if (d[0] !== v) testDone();
  endtask : waitRen

  task automatic chkBlock(input logic [7:0] data, input logic eom, input logic ack);
    @(negedge mclk);
    check({31'h0, irq}, {31'h0, maskOn});
    rdChk(OFS_RBUF, expBuf(data, eom, ack));
    rdChk(OFS_IST, {30'h0, eom, 1'b1});
    wr(OFS_IST, 32'h7);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
  endtask : chkBlock

  task automatic randFrame();
    int            n;
    logic [7:0]    b;
    logic          s;
    n = 2 + $urandom % 2;
    peer_u.sendStart();
    for (int k = 0; k < n; k++) begin
      b = 8'($urandom);
      s = 1'($urandom);
      peer_u.sendBlock(b, k == n - 1, s);
      chkBlock(b, k == n - 1, 1'b1);
    end
  endtask : randFrame

  initial begin
    logic [DW-1:0] keep;
    int            w;
    busReq         = '0;
    rst_n          = 1'b0;
    maskOn         = 1'b1;
    failCount      = 0;
    samplesChecked = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    void'($urandom(32'h31d8));
    foreach (zeroAddr[i]) rdChk(zeroAddr[i], 32'h0);
    wr(OFS_EN, 32'h1);
    keep = $urandom;
    wr(OFS_RCR2, keep);
    wr(OFS_EN, 32'h0);
    rdChk(OFS_RCR2, keep);
    wr(OFS_RCR2, ~keep);
    rdChk(OFS_RCR2, keep);
    wr(OFS_EN, 32'h3);
    wr(OFS_RCR2, 32'h0);
    wr(OFS_RCR1, 32'h1);
    wr(OFS_IMSK, 32'h1);
    wr(OFS_REN, 32'h1);
    waitRen(1'b1);
    repeat (3) randFrame();
    keep = expBuf(8'h5a, 1'b1, 1'b1);
    maskOn = 1'b0;
    wr(OFS_IMSK, 32'h0);
    peer_u.sendStart();
    peer_u.sendBlock(8'h5a, 1'b1, 1'b0);
    chkBlock(8'h5a, 1'b1, 1'b1);
    wr(OFS_RBUF, $urandom);
    rdChk(OFS_RBUF, keep);
    wr(OFS_REN, 32'h0);
    waitRen(1'b0);
    peer_u.sendStart();
    peer_u.sendBlock(8'ha5, 1'b1, 1'b0);
    rdChk(OFS_RBUF, keep);
    rdChk(OFS_IST, 32'h0);
    wr(OFS_ADDR, 32'h8);
    maskOn = 1'b1;
    wr(OFS_IMSK, 32'h1);
    wr(OFS_REN, 32'h1);
    waitRen(1'b1);
    peer_u.sendStart();
    peer_u.sendBlock(8'h13, 1'b1, 1'b1);
    chkBlock(8'h13, 1'b1, 1'b0);
    // a low too long for a bit and too short for a start ends the frame with an error
    peer_u.sendStart();
    peer_u.holdTicks(1'b1, 55);
    peer_u.holdTicks(1'b0, 10);
    rdChk(OFS_IST, 32'h4);
    wr(OFS_IST, 32'h7);
    rdChk(OFS_IST, 32'h0);
    fork
      begin
        peer_u.sendStart();
        peer_u.sendBlock(8'h23, 1'b0, 1'b0);
        peer_u.sendBlock(8'h77, 1'b1, 1'b0);
      end
      begin
        for (w = 0; w < 4000 && cecOe !== 1'b1; w++) @(negedge mclk);
        if (cecOe !== 1'b1) begin
          failCount++;
          testDone();
        end
        wr(OFS_RST, 32'h1);
        @(negedge mclk);
        check({31'h0, cecOe}, 32'h0);
        check({31'h0, cecOut}, 32'h0);
        check({31'h0, irq}, 32'h0);
      end
    join
    foreach (zeroAddr[i]) rdChk(zeroAddr[i], 32'h0);
    rdChk(OFS_EN, 32'h3);
    testDone();
  end
endmodule : cec_reset_and_receive_regs_test
